// [ffmd_pkg.sv]
// Behaviour
// - Latched mode: reading the source register clears the active flag and all its bits.
// - Combine select 0 ANDs enabled axes (freefall), 1 ORs them (motion).
// - Each axis enable includes or excludes that axis; all reset to zero.
// - Latched mode: axis event and polarity bits freeze when the active flag sets.
// - Latched mode blocks new axis events while pending; otherwise bits show live status.
// - Freefall: every enabled axis magnitude at or below the 7-bit threshold.
// - Motion: an enabled axis magnitude strictly above the threshold.
// - Active flag sets when the selected combination holds after debouncing.
// - Source register: active bit 7, zero bit 6, Z 5:4, Y 3:2, X 1:0.
// - Polarity bit is 0 for positive, 1 for negative; flags reset to zero.
// - Axis event and polarity bits read zero while that axis is disabled.
// - Threshold counts 0 to 127 at 1/16 g, reaching 7.9375 g at any range.
// - Low-noise setting limits the effective threshold to 4 g.
// - Threshold register: debounce mode bit 7, threshold bits 6:0, reset zero.
// - Debounce mode 1 clears the counter when the condition drops.
// - Debounce mode 0 decrements the counter per sample while the condition is false.
// - Debounce count register is 8-bit read/write, reset zero, minimum matching samples.
// - Event sets when the debounce counter reaches the programmed count.
// - The debounce counter saturates at the programmed count.
// - One debounce step is one output sample period.
// - The active flag feeds the interrupt enable and routing logic outside.
// - Configuration register: latch 7, combine 6, Z/Y/X enables 5:3, bits 2:0 zero.
// - Unlatched mode: reading the source register clears nothing.
package ffmd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h15;
  localparam logic [7:0] ADDR_SRC = 8'h16;
  localparam logic [7:0] ADDR_THS = 8'h17;
  localparam logic [7:0] ADDR_CNT = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_LATCH_BIT = 7;
  localparam int CFG_COMBINE_BIT = 6;
  localparam int CFG_ZEN_BIT = 5;
  localparam int CFG_YEN_BIT = 4;
  localparam int CFG_XEN_BIT = 3;
  localparam int SRC_ACTIVE_BIT = 7;
  localparam int THS_MODE_BIT = 7;
  localparam int THS_W = 7;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] THS_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [THS_W-1:0] LOW_NOISE_THS_MAX = 7'h40;

  // ----------------------------------------------------------------
  // Sample format and full-scale codes
  // ----------------------------------------------------------------
  localparam int ACC_W = 12;
  localparam logic [1:0] FS_2G = 2'h0;
  localparam logic [1:0] FS_4G = 2'h1;
  localparam logic [1:0] FS_8G = 2'h2;
  localparam int AXIS_X = 0;
  localparam int AXIS_Y = 1;
  localparam int AXIS_Z = 2;

  typedef struct packed {
    logic [ACC_W-1:0] z;
    logic [ACC_W-1:0] y;
    logic [ACC_W-1:0] x;
  } ffmd_axes_s;

  typedef struct packed {
    logic latch_enable;
    logic combine_select;
    logic z_axis_detect_enable;
    logic y_axis_detect_enable;
    logic x_axis_detect_enable;
  } ffmd_cfg_s;

endpackage

// [ffmd_axis_cmp.sv]
`timescale 1ns/1ns
module ffmd_axis_cmp #(
  parameter int W = ffmd_pkg::ACC_W
) (
  input wire logic [W-1:0] sample_i,
  input wire logic [ffmd_pkg::THS_W-1:0] ths_i,
  input wire logic [1:0] full_scale_i,
  input wire logic low_noise_i,
  output logic above_o,
  output logic neg_o
);

  localparam int BASE = W - 8;

  logic [W-1:0] mag;
  logic [ffmd_pkg::THS_W-1:0] ths_eff;
  logic [W+1:0] lim;
  int sh;

  // ----------------------------------------------------------------
  // Magnitude against threshold scaled to the sample's full scale
  // ----------------------------------------------------------------
  always_comb begin
    mag = sample_i[W-1] ? W'(~sample_i + 1'b1) : sample_i;
    ths_eff = ths_i;
    if (low_noise_i && (ths_i > ffmd_pkg::LOW_NOISE_THS_MAX)) begin
      ths_eff = ffmd_pkg::LOW_NOISE_THS_MAX;
    end
    // One threshold step is a sixteenth of a g whatever the range.
    unique case (full_scale_i)
      ffmd_pkg::FS_2G: sh = BASE + 2;
      ffmd_pkg::FS_4G: sh = BASE + 1;
      default: sh = BASE;
    endcase
    lim = (W+2)'(ths_eff) << sh;
    above_o = {2'b00, mag} > lim;
    neg_o = sample_i[W-1];
  end

endmodule

// [ffmd_debounce.sv]
`timescale 1ns/1ns
module ffmd_debounce #(
  parameter int CW = ffmd_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic step_i,
  input wire logic cond_i,
  input wire logic clear_mode_i,
  input wire logic [CW-1:0] limit_i,
  input wire logic clear_i,
  output logic [CW-1:0] nxt_cnt_o
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [CW-1:0] base;

  // ----------------------------------------------------------------
  // Sample counter
  // ----------------------------------------------------------------
  always_comb begin
    // A sample that lands with the clearing read counts from zero, so it is not lost.
    base = clear_i ? '0 : cnt_ff;
    nxt_cnt = base;
    if (step_i) begin
      if (cond_i) begin
        // Clamping also covers a limit lowered below the running count.
        nxt_cnt = (base < limit_i) ? CW'(base + 1'b1) : limit_i;
      end else if (clear_mode_i) begin
        nxt_cnt = '0;
      end else if (base != '0) begin
        nxt_cnt = CW'(base - 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign nxt_cnt_o = nxt_cnt;

endmodule

// [ffmd_top.sv]
`timescale 1ns/1ns
module ffmd_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sample_ready_i,
  input wire ffmd_pkg::ffmd_axes_s accel_i,
  input wire logic [1:0] full_scale_i,
  input wire logic low_noise_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic event_active_o
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  ffmd_pkg::ffmd_cfg_s cfg_ff;
  ffmd_pkg::ffmd_cfg_s nxt_cfg;
  logic [7:0] ths_ff;
  logic [7:0] nxt_ths;
  logic [7:0] cnt_lim_ff;
  logic [7:0] nxt_cnt_lim;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam int SEL_CFG = 0;
  localparam int SEL_SRC = 1;
  localparam int SEL_THS = 2;
  localparam int SEL_CNT = 3;

  // One-hot select of the four registers; unmapped addresses select none.
  function automatic logic [3:0] reg_sel(input logic [7:0] addr);
    logic [3:0] sel;
    sel = 4'h0;
    sel[SEL_CFG] = (addr == ffmd_pkg::ADDR_CFG);
    sel[SEL_SRC] = (addr == ffmd_pkg::ADDR_SRC);
    sel[SEL_THS] = (addr == ffmd_pkg::ADDR_THS);
    sel[SEL_CNT] = (addr == ffmd_pkg::ADDR_CNT);
    return sel;
  endfunction

  logic [3:0] wr_sel;
  logic [3:0] rd_sel;

  assign wr_sel = reg_wr_i ? reg_sel(reg_addr_i) : 4'h0;
  assign rd_sel = reg_rd_i ? reg_sel(reg_addr_i) : 4'h0;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_ths = ths_ff;
    nxt_cnt_lim = cnt_lim_ff;
    // The source register is read-only, so a write to it changes nothing.
    if (wr_sel[SEL_CFG]) begin
      nxt_cfg.latch_enable = reg_wdata_i[ffmd_pkg::CFG_LATCH_BIT];
      nxt_cfg.combine_select = reg_wdata_i[ffmd_pkg::CFG_COMBINE_BIT];
      nxt_cfg.z_axis_detect_enable = reg_wdata_i[ffmd_pkg::CFG_ZEN_BIT];
      nxt_cfg.y_axis_detect_enable = reg_wdata_i[ffmd_pkg::CFG_YEN_BIT];
      nxt_cfg.x_axis_detect_enable = reg_wdata_i[ffmd_pkg::CFG_XEN_BIT];
    end
    if (wr_sel[SEL_THS]) begin
      nxt_ths = reg_wdata_i;
    end
    if (wr_sel[SEL_CNT]) begin
      nxt_cnt_lim = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cfg_ff <= ffmd_pkg::ffmd_cfg_s'(ffmd_pkg::CFG_RESET[7:3]);
      ths_ff <= ffmd_pkg::THS_RESET;
      cnt_lim_ff <= ffmd_pkg::CNT_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
      ths_ff <= nxt_ths;
      cnt_lim_ff <= nxt_cnt_lim;
    end
  end

  // ----------------------------------------------------------------
  // Per-axis comparison
  // ----------------------------------------------------------------
  logic [2:0] axis_en;
  logic [2:0] axis_above;
  logic [2:0] axis_neg;
  logic [2:0][ffmd_pkg::ACC_W-1:0] axis_data;

  assign axis_en = {cfg_ff.z_axis_detect_enable, cfg_ff.y_axis_detect_enable,
                    cfg_ff.x_axis_detect_enable};
  assign axis_data = {accel_i.z, accel_i.y, accel_i.x};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_axis
      ffmd_axis_cmp #(
        .W(ffmd_pkg::ACC_W)
      ) u_cmp (
        .sample_i(axis_data[g]),
        .ths_i(ths_ff[ffmd_pkg::THS_W-1:0]),
        .full_scale_i(full_scale_i),
        .low_noise_i(low_noise_i),
        .above_o(axis_above[g]),
        .neg_o(axis_neg[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Axis combination
  // ----------------------------------------------------------------
  logic [2:0] axis_hit;
  logic cond;

  always_comb begin
    if (cfg_ff.combine_select) begin
      axis_hit = axis_above & axis_en;
      cond = |axis_hit;
    end else begin
      axis_hit = ~axis_above & axis_en;
      // With no axis enabled the block is off, so freefall never holds.
      cond = (axis_en != 3'h0) && ((axis_hit | ~axis_en) == 3'h7);
    end
  end

  // ----------------------------------------------------------------
  // Debounce
  // ----------------------------------------------------------------
  logic rd_src;
  logic rd_clr;
  logic [7:0] nxt_dbc;

  assign rd_src = rd_sel[SEL_SRC];
  assign rd_clr = rd_src && cfg_ff.latch_enable;

  ffmd_debounce #(
    .CW(ffmd_pkg::CNT_W)
  ) u_dbc (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .step_i(sample_ready_i),
    .cond_i(cond),
    .clear_mode_i(ths_ff[ffmd_pkg::THS_MODE_BIT]),
    .limit_i(cnt_lim_ff),
    .clear_i(rd_clr),
    .nxt_cnt_o(nxt_dbc)
  );

  // ----------------------------------------------------------------
  // Event flag
  // ----------------------------------------------------------------
  logic ea_ff;
  logic nxt_ea;
  logic ea_set;
  logic flags_hold;
  logic flags_load;
  logic flags_clear;

  always_comb begin
    ea_set = sample_ready_i && cond && (nxt_dbc == cnt_lim_ff);
    nxt_ea = ea_ff;
    if (cfg_ff.latch_enable) begin
      // A new event in the read cycle is kept: the set wins over the clear.
      nxt_ea = ea_set || (ea_ff && !rd_clr);
    end else if (sample_ready_i) begin
      if (ea_set) begin
        nxt_ea = 1'b1;
      end else if (nxt_dbc == 8'h00) begin
        nxt_ea = 1'b0;
      end
    end
    flags_hold = cfg_ff.latch_enable && ea_ff && !rd_clr;
    flags_load = !flags_hold && sample_ready_i;
    flags_clear = !flags_hold && !sample_ready_i && rd_clr;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ea_ff <= 1'b0;
    end else begin
      ea_ff <= nxt_ea;
    end
  end

  // ----------------------------------------------------------------
  // Per-axis event and polarity bits
  // ----------------------------------------------------------------
  logic [5:0] src_flags;

  generate
    for (g = 0; g < 3; g++) begin : gen_flag
      logic evt_ff;
      logic nxt_evt;
      logic pol_ff;
      logic nxt_pol;

      always_comb begin
        nxt_evt = evt_ff;
        nxt_pol = pol_ff;
        if (flags_load) begin
          nxt_evt = axis_hit[g];
          nxt_pol = axis_hit[g] & axis_neg[g];
        end else if (flags_clear) begin
          nxt_evt = 1'b0;
          nxt_pol = 1'b0;
        end
      end

      always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
          evt_ff <= 1'b0;
          pol_ff <= 1'b0;
        end else begin
          evt_ff <= nxt_evt;
          pol_ff <= nxt_pol;
        end
      end

      // Bits latched before an axis was disabled are hidden, not lost.
      assign src_flags[2*g+1] = evt_ff & axis_en[g];
      assign src_flags[2*g] = pol_ff & axis_en[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ffmd_pkg::ADDR_CFG: nxt_rdata = {cfg_ff, 3'h0};
        // The pre-clear value is taken on the same edge that clears it.
        ffmd_pkg::ADDR_SRC: nxt_rdata = {ea_ff, 1'b0, src_flags};
        ffmd_pkg::ADDR_THS: nxt_rdata = ths_ff;
        ffmd_pkg::ADDR_CNT: nxt_rdata = cnt_lim_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_ff <= ffmd_pkg::RDATA_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign event_active_o = ea_ff;

endmodule

// [ffmd_top_properties.sv]
`timescale 1ns/1ns
module ffmd_top_properties (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sample_ready_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic event_active_o
);
  // ----------------------------------------------------------------
  // Shadow of the latch and axis enable settings
  // ----------------------------------------------------------------
  logic latch_ff;
  logic nxt_latch;
  logic [2:0] en_ff;
  logic [2:0] nxt_en;
  logic [5:0] off_mask;
  logic rd_src;
  assign rd_src = reg_rd_i && (reg_addr_i == ffmd_pkg::ADDR_SRC);
  always_comb begin
    off_mask = {{2{!en_ff[2]}}, {2{!en_ff[1]}}, {2{!en_ff[0]}}};
    nxt_latch = latch_ff;
    nxt_en = en_ff;
    if (!rst_b_i) begin
      nxt_latch = 1'b0;
      nxt_en = 3'h0;
    end else if (reg_wr_i && (reg_addr_i == ffmd_pkg::ADDR_CFG)) begin
      nxt_latch = reg_wdata_i[ffmd_pkg::CFG_LATCH_BIT];
      nxt_en = {reg_wdata_i[ffmd_pkg::CFG_ZEN_BIT], reg_wdata_i[ffmd_pkg::CFG_YEN_BIT],
                reg_wdata_i[ffmd_pkg::CFG_XEN_BIT]};
    end
  end
  always_ff @(posedge clk_i) begin
    latch_ff <= nxt_latch;
    en_ff <= nxt_en;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_ea_in_read: assert property (rd_src |=> reg_rdata_o[7] == $past(event_active_o))
    else $error("source read lost the active flag");
  chk_bit6_zero: assert property (rd_src |=> !reg_rdata_o[6])
    else $error("source bit 6 not zero");
  chk_cfg_pad_zero: assert property (
    reg_rd_i && (reg_addr_i == ffmd_pkg::ADDR_CFG) |=> reg_rdata_o[2:0] == 3'h0)
    else $error("config low bits not zero");
  chk_unmapped_zero: assert property (
    reg_rd_i && !(reg_addr_i inside {[ffmd_pkg::ADDR_CFG:ffmd_pkg::ADDR_CNT]})
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  chk_ea_on_sample: assert property (!sample_ready_i && !rd_src |=> !$rose(event_active_o))
    else $error("active flag rose without a sample");
  chk_latch_clear: assert property (latch_ff && rd_src && !sample_ready_i |=> !event_active_o)
    else $error("latched read did not clear the flag");
  chk_latch_hold: assert property (
    latch_ff && event_active_o && !rd_src && !reg_wr_i |=> event_active_o)
    else $error("latched flag dropped without a read");
  chk_live_read_keeps: assert property (
    !latch_ff && rd_src && !sample_ready_i |=> $stable(event_active_o))
    else $error("unlatched read changed the flag");
  chk_off_axis_zero: assert property (
    rd_src |=> (reg_rdata_o[5:0] & $past(off_mask)) == 6'h00)
    else $error("disabled axis bits not zero");
endmodule
bind ffmd_top ffmd_top_properties u_chk (.clk_i, .rst_b_i, .sample_ready_i, .reg_addr_i,
  .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .event_active_o);

// [ffmd_host.sv]
`timescale 1ns/1ns
module ffmd_host (
  input wire logic clk_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  // ----------------------------------------------------------------
  // Register accesses
  // ----------------------------------------------------------------
  logic [7:0] exp_q[$];
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // Address is inverted after each access and data after each write, so no read leans on stale values.
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  task automatic get(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
  endtask
endmodule

// [test_freefall_motion_detector.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %0t got %h expected %h", $time, g, e); end end
module test_freefall_motion_detector;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sample_ready_i = 1'b0;
  ffmd_pkg::ffmd_axes_s accel_i = '0;
  logic [1:0] full_scale_i = ffmd_pkg::FS_8G;
  logic low_noise_i = 1'b0;
  logic [7:0] reg_addr_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic event_active_o;
  logic rd_pend = 1'b0;
  logic [7:0] exp_v;
  logic [31:0] seed = 32'd20;
  logic [31:0] rv;
  int n_mismatch = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  ffmd_top u_dut (.clk_i, .rst_b_i, .sample_ready_i, .accel_i, .full_scale_i, .low_noise_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .event_active_o);
  ffmd_host u_host (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Read data lands one edge after the strobe, so the oldest note is compared then.
  always @(posedge clk_i) rd_pend <= reg_rd_i;
  always @(negedge clk_i) begin
    if (rd_pend) begin
      exp_v = u_host.exp_q.pop_front();
      `CHK(reg_rdata_o, exp_v)
    end
  end
  task automatic src(input logic [7:0] e);
    u_host.get(ffmd_pkg::ADDR_SRC, e);
  endtask
  task automatic cfg3(input logic [7:0] c, input logic [7:0] t, input logic [7:0] n);
    @(negedge clk_i);
    rst_b_i = 1'b0;
    repeat (5) @(negedge clk_i);
    rst_b_i = 1'b1;
    u_host.put(ffmd_pkg::ADDR_CNT, n);
    u_host.put(ffmd_pkg::ADDR_THS, t);
    u_host.put(ffmd_pkg::ADDR_CFG, c);
  endtask
  task automatic samp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
    @(negedge clk_i);
    accel_i = {z, y, x};
    sample_ready_i = 1'b1;
    @(negedge clk_i);
    sample_ready_i = 1'b0;
  endtask
  task automatic rng(input logic [1:0] fs, input logic ln, input logic [7:0] t,
    input logic [11:0] x, input logic [7:0] e);
    cfg3(8'h48, t, 8'h00);
    full_scale_i = fs;
    low_noise_i = ln;
    samp(x, 12'h000, 12'h000);
    src(e);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end
  initial begin
    cfg3(8'h00, 8'h00, 8'h00);
    rst_b_i = 1'b0;
    repeat (5) @(negedge clk_i);
    rst_b_i = 1'b1;
    u_host.get(ffmd_pkg::ADDR_CFG, ffmd_pkg::CFG_RESET);
    src(8'h00);
    u_host.get(ffmd_pkg::ADDR_THS, ffmd_pkg::THS_RESET);
    u_host.get(ffmd_pkg::ADDR_CNT, ffmd_pkg::CNT_RESET);
    u_host.get(8'h19, 8'h00);
    rv = rnd();
    u_host.put(ffmd_pkg::ADDR_CFG, 8'hFF);
    u_host.get(ffmd_pkg::ADDR_CFG, 8'hF8);
    u_host.put(ffmd_pkg::ADDR_THS, rv[7:0]);
    u_host.get(ffmd_pkg::ADDR_THS, rv[7:0]);
    u_host.put(ffmd_pkg::ADDR_CNT, rv[15:8]);
    u_host.get(ffmd_pkg::ADDR_CNT, rv[15:8]);
    u_host.put(ffmd_pkg::ADDR_SRC, 8'hFF);
    src(8'h00);
    $display("test registers done");
    cfg3(8'h48, 8'h10, 8'h02);
    samp(12'h100, 12'h7FF, 12'h7FF);
    src(8'h00);
    rv = rnd() & 32'hFF;
    repeat (3) samp(12'hEFF - rv[11:0], 12'h000, 12'h000);
    `CHK(event_active_o, 1'b1)
    src(8'h83);
    src(8'h83);
    repeat (2) samp(12'h000, 12'h000, 12'h000);
    src(8'h00);
    $display("test motion done");
    for (int m = 0; m < 2; m++) begin
      cfg3(8'h48, {m[0], 7'h10}, 8'h03);
      for (int k = 0; k < 5; k++) begin
        samp((k == 2) ? 12'h000 : 12'h180, 12'h000, 12'h000);
      end
      src(m ? 8'h02 : 8'h82);
    end
    $display("test debounce done");
    cfg3(8'h30, 8'h10, 8'h00);
    samp(12'h7FF, 12'h100, 12'h0F0);
    src(8'hA8);
    $display("test freefall done");
    cfg3(8'hC8, 8'h10, 8'h00);
    samp(12'h200, 12'h000, 12'h000);
    samp(12'hE00, 12'h000, 12'h000);
    src(8'h82);
    src(8'h00);
    `CHK(event_active_o, 1'b0)
    samp(12'hE00, 12'h000, 12'h000);
    u_host.put(ffmd_pkg::ADDR_CFG, 8'hC0);
    src(8'h80);
    $display("test latched done");
    rng(ffmd_pkg::FS_2G, 1'b0, 8'h10, 12'h400, 8'h00);
    rng(ffmd_pkg::FS_2G, 1'b0, 8'h10, 12'h401, 8'h82);
    rng(ffmd_pkg::FS_8G, 1'b1, 8'h50, 12'h401, 8'h82);
    rng(ffmd_pkg::FS_4G, 1'b0, 8'h7F, 12'h7FF, 8'h00);
    $display("test threshold done");
    repeat (2) @(posedge clk_i);
    conclude();
  end
endmodule
